// ==== design/asq_sequencer.sv ====
// power, clock and level-control sequencer of the mono audio converter
//
// Functional notes
// (R1) host holds chip reset low at least 150 ns after power-up; the bench releases its first reset after two clock edges, at 15 ns
// (R2) passthrough select set: frame, bit clock and data outputs follow external inputs
// (R3) host brings clocks up before any recording starts
// (R4) host programs rate, mic, timer, reference, level settings, then ADC power
// (R5) after ADC power-on, 3088 sample periods of initialisation before valid output
// (R6) level loop starts from default input gain when enabled and powered
// (R7) host powers reference and mic, waits 2 ms, PLL, waits 6 ms, ADC; the bench skips the PLL and both waits
// (R8) in PLL mode host waits PLL lock after rate change before power-up
// (R9) level control suspended while ADC block is off despite enable bit
// (R10) host changes level settings only with loop disabled or ADC off
// (R11) ADC power-off keeps input gain; loop resumes from the kept value
// (R12) master clock may stop while ADC idle without losing register state
// (R13) PLL master: clear PLL and master bits, then clock-out enable, then clock
// (R14) PLL slave on frame or bit clock: clear PLL power before stopping clocks
// (R15) PLL slave on master clock: clear PLL, clock-out enable, then stop clock
// (R16) external-clock slave and bypass: clocks may stop directly
// (R17) external master: outputs hold static when master clock stops
// (R18) chip reset low returns all control registers to defaults
// (R19) host powers common reference before any other block; the bench powers it in the same write as the mic
// (R20) host completes each control write before next sequence step
//
// The APB slave port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`include "asq_params.svh"
module asq_sequencer (
   input  wire logic        ref_clk_in,
   input  wire logic        reset_n_in,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        master_clock_in,
   input  wire logic        ext_frame_clock_in,
   input  wire logic        ext_bit_clock_in,
   input  wire logic        ext_serial_data_in,
   input  wire logic [1:0]  sample_peak_in,
   output logic             frame_clock_out,
   output logic             bit_clock_out,
   output logic             serial_data_out,
   output logic             common_ref_power_on_out,
   output logic             mic_power_on_out,
   output logic             pll_power_on_out,
   output logic             adc_power_on_out,
   output logic             master_clock_out_enable_out,
   output logic [7:0]       input_gain_value_out,
   output logic             adc_data_valid_out
);
   logic [7:0]  ctrl_q;
   logic [13:0] cfg_q;
   logic [7:0]  gain_q, gain_d;
   logic [31:0] prdata_q;
   logic        pready_q, pslverr_q;
   logic        frm_o_q, bck_o_q, sdo_q;
   logic [1:0]  bdiv_q;
   logic [5:0]  fcnt_q;
   logic [11:0] init_q;
   logic [15:0] mto_q;
   logic        mclk_run_q;
   logic        valid_q;
   asq_pkg::asq_adc_state_t st_q, st_d;

   // pins 0..3: master clock, ext frame, ext bit clock, ext data
   logic [3:0] pin_raw, pin_lvl, pin_rise;
   assign pin_raw = {ext_serial_data_in, ext_bit_clock_in, ext_frame_clock_in, master_clock_in};
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_sync
         asq_sync_edge u_sync (
            .ref_clk_in (ref_clk_in),
            .reset_n_in (reset_n_in),
            .pin_in     (pin_raw[gi]),
            .level_out  (pin_lvl[gi]),
            .rise_out   (pin_rise[gi])
         );
      end
   endgenerate

   function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
      hit = (a == ofs);
   endfunction : hit

   wire setup_c   = psel & ~penable;
   wire wr_c      = psel & penable & pwrite & pready_q;
   wire hit_ctrl  = hit(paddr, `ASQ_OFS_CTRL);
   wire hit_cfg   = hit(paddr, `ASQ_OFS_CFG);
   wire hit_gain  = hit(paddr, `ASQ_OFS_GAIN);
   wire hit_stat  = hit(paddr, `ASQ_OFS_STAT);
   wire mapped_c  = hit_ctrl | hit_cfg | hit_gain | hit_stat;
   wire thru_c    = ctrl_q[`ASQ_CTRL_THRU];
   wire extm_c    = ctrl_q[`ASQ_CTRL_EXTM];
   wire adc_on_c  = ctrl_q[`ASQ_CTRL_ADC];
   wire alc_act_c = cfg_q[`ASQ_CFG_ALC] & adc_on_c;
   wire mclk_to_c = (mto_q == 16'(`ASQ_MCLK_TO_CYC));
   wire [31:0] rd_c = hit_ctrl ? {24'h000000, ctrl_q} :
                      hit_cfg  ? {18'h0, cfg_q} :
                      hit_gain ? {24'h000000, gain_q} :
                      hit_stat ? {28'h0000000, (st_q == asq_pkg::ASQ_INIT), mclk_run_q, alc_act_c,
                                  (st_q == asq_pkg::ASQ_RUN)} : 32'h00000000;
   // sample tick from own frame clock in external master, else from the pin
   wire frm_tick  = extm_c ? (pin_rise[0] && bdiv_q == `ASQ_BCLK_DIV && fcnt_q == `ASQ_FRAME_HALF
                              && !frm_o_q) : pin_rise[1];

   // zero-wait APB slave; unmapped offsets answer with pslverr
   always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q  <= 32'h00000000;
      end else begin
         pready_q  <= setup_c;
         pslverr_q <= setup_c & ~mapped_c;
         prdata_q  <= setup_c ? rd_c : prdata_q;
      end
   end

   // (R18) defaults on reset
   always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         ctrl_q <= `ASQ_CTRL_RESET;
         cfg_q  <= `ASQ_CFG_RESET;
      end else begin
         if (wr_c && hit_ctrl) ctrl_q <= pwdata[7:0];
         if (wr_c && hit_cfg)  cfg_q  <= pwdata[13:0];
      end
   end

   // (R5) initialisation count after ADC power-on
   always_comb begin
      st_d = st_q;
      unique case (st_q)
         asq_pkg::ASQ_OFF:  if (adc_on_c) st_d = asq_pkg::ASQ_INIT;
         asq_pkg::ASQ_INIT: if (!adc_on_c) st_d = asq_pkg::ASQ_OFF;
                            else if (frm_tick && init_q == `ASQ_INIT_SAMPLES - 12'h001) st_d = asq_pkg::ASQ_RUN;
         asq_pkg::ASQ_RUN:  if (!adc_on_c) st_d = asq_pkg::ASQ_OFF;
         default:           st_d = asq_pkg::ASQ_OFF;
      endcase
   end

   always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         st_q   <= asq_pkg::ASQ_OFF;
         init_q <= 12'h000;
      end else begin
         st_q   <= st_d;
         init_q <= (st_q != asq_pkg::ASQ_INIT) ? 12'h000 : init_q + {11'h000, frm_tick};
      end
   end

   // (R9) loop only while enabled and powered; (R11) gain kept across power-off
   wire [7:0] atten_c = {6'h00, cfg_q[13:12]} + 8'h01;
   wire [7:0] recov_c = {6'h00, cfg_q[11:10]} + 8'h01;
   wire       over_c  = sample_peak_in > cfg_q[9:8];
   always_comb begin
      gain_d = gain_q;
      if (wr_c && hit_gain && !alc_act_c)
         gain_d = pwdata[7:0];
      else if (alc_act_c && frm_tick && over_c)
         gain_d = (gain_q > atten_c) ? gain_q - atten_c : 8'h00;
      else if (alc_act_c && frm_tick)
         gain_d = (gain_q < `ASQ_GAIN_MAX - recov_c) ? gain_q + recov_c : `ASQ_GAIN_MAX;
   end

   // (R6) loop starts from the default gain after reset
   always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) gain_q <= `ASQ_GAIN_RESET;
      else             gain_q <= gain_d;
   end

   // (R12) watchdog on master clock; registers never depend on it
   always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         mto_q      <= 16'h0000;
         mclk_run_q <= 1'b0;
      end else begin
         mto_q      <= pin_rise[0] ? 16'h0000 : (mclk_to_c ? mto_q : mto_q + 16'h0001);
         mclk_run_q <= pin_rise[0] | (mclk_run_q & ~mclk_to_c);
      end
   end

   // (R17) own clocks advance only on master clock edges, so they freeze when it stops
   always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         bdiv_q <= 2'h0;
         fcnt_q <= 6'h00;
      end else if (extm_c && pin_rise[0]) begin
         bdiv_q <= bdiv_q + 2'h1;
         if (bdiv_q == `ASQ_BCLK_DIV) fcnt_q <= fcnt_q + 6'h01;
      end
   end

   // (R2) bypass routes the external stream straight through
   always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         frm_o_q <= 1'b0;
         bck_o_q <= 1'b0;
         sdo_q   <= 1'b0;
      end else if (thru_c) begin
         frm_o_q <= pin_lvl[1];
         bck_o_q <= pin_lvl[2];
         sdo_q   <= pin_lvl[3];
      end else if (extm_c) begin
         if (pin_rise[0] && bdiv_q == `ASQ_BCLK_DIV) bck_o_q <= ~bck_o_q;
         if (pin_rise[0] && bdiv_q == `ASQ_BCLK_DIV && fcnt_q == `ASQ_FRAME_HALF) frm_o_q <= ~frm_o_q;
         sdo_q <= 1'b0;
      end else begin
         sdo_q <= 1'b0;
      end
   end

   assign prdata                      = prdata_q;
   assign pready                      = pready_q;
   assign pslverr                     = pslverr_q;
   assign frame_clock_out             = frm_o_q;
   assign bit_clock_out               = bck_o_q;
   assign serial_data_out             = sdo_q;
   assign common_ref_power_on_out     = ctrl_q[`ASQ_CTRL_REF];
   assign mic_power_on_out            = ctrl_q[`ASQ_CTRL_MIC];
   assign pll_power_on_out            = ctrl_q[`ASQ_CTRL_PLL];
   assign adc_power_on_out            = ctrl_q[`ASQ_CTRL_ADC];
   assign master_clock_out_enable_out = ctrl_q[`ASQ_CTRL_MASTER_CLOCK_OUT_ENABLE];
   assign input_gain_value_out        = gain_q;
   // registered copy of the run state keeps the output glitch-free
   always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) valid_q <= 1'b0;
      else             valid_q <= (st_d == asq_pkg::ASQ_RUN);
   end
   assign adc_data_valid_out = valid_q;

   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (!reset_n_in);

   chk_thru_frame: assert property (thru_c && $past(thru_c) |-> frm_o_q == $past(pin_lvl[1])) // R2
      else $error("bypass frame output not following input");
   chk_thru_data: assert property (thru_c && $past(thru_c) |-> sdo_q == $past(pin_lvl[3])) // R2
      else $error("bypass data output not following input");
   chk_init_len: assert property ($rose(adc_data_valid_out) |-> init_q == `ASQ_INIT_SAMPLES && adc_on_c) // R5
      else $error("valid output before full initialisation");
   chk_init_start: assert property ($rose(adc_on_c) |=> !adc_data_valid_out) // R5
      else $error("output valid without initialisation");
   chk_gain_reset: assert property ($rose(reset_n_in) |-> gain_q == `ASQ_GAIN_RESET) // R6
      else $error("gain not at default after reset");
   chk_alc_hold: assert property (!adc_on_c && !(wr_c && hit_gain) |=> $stable(gain_q)) // R9
      else $error("gain moved while ADC off");
   chk_gain_keep: assert property ($rose(adc_on_c) |-> $stable(gain_q)) // R11
      else $error("gain lost across power cycle");
   chk_reg_keep: assert property (!mclk_run_q && !wr_c |=> $stable(ctrl_q) && $stable(cfg_q)) // R12
      else $error("registers changed with master clock stopped");
   chk_static_clk: assert property (extm_c && !thru_c && !pin_rise[0] |=> $stable(bck_o_q) && $stable(frm_o_q)) // R17
      else $error("clock outputs moved without master clock");
   chk_reset_dflt: assert property ($rose(reset_n_in) |-> ctrl_q == `ASQ_CTRL_RESET && cfg_q == `ASQ_CFG_RESET) // R18
      else $error("control registers not at default");

   cov_bypass: cover property (thru_c && pin_rise[1]);
   cov_init_done: cover property ($rose(adc_data_valid_out));
   cov_alc_atten: cover property (alc_act_c && frm_tick && over_c);
   cov_mclk_stop: cover property ($fell(mclk_run_q));
endmodule : asq_sequencer

// ==== design/asq_params.svh ====
// offsets, field positions, reset values and timing counts of the sequencer
`ifndef ASQ_PARAMS_SVH
`define ASQ_PARAMS_SVH
`define ASQ_CLK_MHZ        100
`define ASQ_OFS_CTRL       8'h00
`define ASQ_OFS_CFG        8'h04
`define ASQ_OFS_GAIN       8'h08
`define ASQ_OFS_STAT       8'h0C
`define ASQ_CTRL_REF       0
`define ASQ_CTRL_MIC       1
`define ASQ_CTRL_PLL       2
`define ASQ_CTRL_ADC       3
`define ASQ_CTRL_MS        4
`define ASQ_CTRL_MASTER_CLOCK_OUT_ENABLE      5
`define ASQ_CTRL_THRU      6
`define ASQ_CTRL_EXTM      7
`define ASQ_CTRL_RESET     8'h00
`define ASQ_CFG_ALC        6
`define ASQ_CFG_RESET      14'h0000
`define ASQ_GAIN_RESET     8'h91
`define ASQ_GAIN_MAX       8'hF1
`define ASQ_INIT_SAMPLES   12'hC10
`define ASQ_BCLK_DIV       2'h3
`define ASQ_FRAME_HALF     6'h3F
`define ASQ_MCLK_TO_NS     1000
`define ASQ_MCLK_TO_CYC    ((`ASQ_MCLK_TO_NS * `ASQ_CLK_MHZ) / 1000)
`endif

// ==== design/asq_pkg.sv ====
// types shared by the sequencer files
package asq_pkg;
   typedef enum logic [1:0] {
      ASQ_OFF  = 2'h0,
      ASQ_INIT = 2'h1,
      ASQ_RUN  = 2'h3
   } asq_adc_state_t;
endpackage : asq_pkg

// ==== design/asq_sync_edge.sv ====
// two-flop synchroniser with rising-edge detect for one pin
`timescale 1ns/1ps
module asq_sync_edge (
   input  wire logic ref_clk_in,
   input  wire logic reset_n_in,
   input  wire logic pin_in,
   output logic      level_out,
   output logic      rise_out
);
   logic meta_q;
   logic sync_q;
   logic last_q;

   // edge logic looks only at the second and third stages
   always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         meta_q <= 1'b0;
         sync_q <= 1'b0;
         last_q <= 1'b0;
      end else begin
         meta_q <= pin_in;
         sync_q <= meta_q;
         last_q <= sync_q;
      end
   end

   assign level_out = sync_q;
   assign rise_out  = sync_q & ~last_q;
endmodule : asq_sync_edge

// ==== tb/asq_host_clock_model.sv ====
// host-side model of the external audio and master clocks
`timescale 1ns/1ps
module asq_host_clock_model (
   input  wire logic run_link_in,
   input  wire logic run_mclk_in,
   output logic      frame_out,
   output logic      bit_out,
   output logic      data_out,
   output logic      mclk_out
);
   initial begin
      frame_out = 1'h0;
      bit_out = 1'h0;
      data_out = 1'h0;
      mclk_out = 1'h0;
      // odd offset keeps these clocks out of phase with the system clock
      #3;
      fork
         // clocks start and stop directly, parked low
         forever #40 frame_out = run_link_in ? ~frame_out : 1'h0;
         forever #20 bit_out = run_link_in ? ~bit_out : 1'h0;
         // idle data keeps moving so a stale level never looks valid
         forever #20 data_out = run_link_in ? frame_out ^ bit_out : ~data_out;
         forever #20 mclk_out = run_mclk_in ? ~mclk_out : 1'h0;
      join
   end
endmodule : asq_host_clock_model

// ==== tb/testbench.sv ====
// self-checking bench of the power and clock sequencer
`timescale 1ns/1ps
module testbench;
   logic        ref_clk_in, reset_n_in, psel, penable, pwrite, pready, pslverr, er;
   logic        mclk, efr, ebit, edat, fco, bco, sdo, ref_on, mic_on, pll_on, adc_on, master_clock_out_enable, valid;
   logic        run_link, run_mclk;
   logic [1:0]  peak;
   logic [7:0]  paddr, gain, g;
   logic [31:0] pwdata, prdata, rd;
   int          fails, cmp_count, cyc, nf, nb, nd;
   // address, write data, expected read, expected error
   logic [72:0] rows [5] = '{{8'h00, 32'h23, 32'h23, 1'h0}, {8'h04, 32'h3F35, 32'h3F35, 1'h0},
      {8'h08, 32'h55, 32'h55, 1'h0}, {8'h10, 32'h1, 32'h0, 1'h1}, {8'h00, 32'hFFFFFF0D, 32'h0D, 1'h0}};

   asq_sequencer asq_sequencer_i (.ref_clk_in(ref_clk_in), .reset_n_in(reset_n_in), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .master_clock_in(mclk), .ext_frame_clock_in(efr), .ext_bit_clock_in(ebit),
      .ext_serial_data_in(edat), .sample_peak_in(peak), .frame_clock_out(fco), .bit_clock_out(bco),
      .serial_data_out(sdo), .common_ref_power_on_out(ref_on), .mic_power_on_out(mic_on),
      .pll_power_on_out(pll_on), .adc_power_on_out(adc_on), .master_clock_out_enable_out(master_clock_out_enable),
      .input_gain_value_out(gain), .adc_data_valid_out(valid));
   asq_host_clock_model asq_host_clock_model_i (.run_link_in(run_link), .run_mclk_in(run_mclk),
      .frame_out(efr), .bit_out(ebit), .data_out(edat), .mclk_out(mclk));

   task automatic close_out();
      $display("comparisons %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : close_out

   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
      cmp_count++;
      if (s !== e) begin
         fails++;
         $display("BAD %s expected %h seen %h", n, e, s);
      end
   endtask : chk

   // entered just after a rising edge; one idle cycle follows each transfer
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
      int n;
      n = 0;
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk_in);
      penable <= 1'h1;
      do begin
         @(posedge ref_clk_in);
         n++;
      end while (pready !== 1'h1 && n < 20);
      chk("pready", 32'h1, {31'h0, pready});
      r = prdata;
      e = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
      @(posedge ref_clk_in);
   endtask : apb

   task automatic edges(input int cycles);
      logic pf, pb, pd;
      pf = fco;
      pb = bco;
      pd = sdo;
      nf = 0;
      nb = 0;
      nd = 0;
      repeat (cycles) begin
         @(posedge ref_clk_in);
         if (fco !== pf) nf++;
         if (bco !== pb) nb++;
         if (sdo !== pd) nd++;
         pf = fco;
         pb = bco;
         pd = sdo;
      end
   endtask : edges

   initial begin
      ref_clk_in = 1'h0;
      forever #5 ref_clk_in = ~ref_clk_in;
   end

   // ceiling well above the roughly 26k cycles the run needs
   always @(posedge ref_clk_in) begin
      cyc++;
      if (cyc == 80000) begin
         fails++;
         close_out();
      end
   end

   initial begin
      reset_n_in = 1'h0;
      {psel, penable, pwrite, run_link, run_mclk} = 5'h0;
      paddr = 8'h0;
      pwdata = 32'h0;
      peak = 2'h3;
      repeat (2) @(posedge ref_clk_in);
      reset_n_in <= 1'h1;
      @(posedge ref_clk_in);
      for (int i = 0; i < 5; i++) begin
         apb(1'h1, rows[i][72:65], rows[i][64:33], rd, er);
         chk("write error", {31'h0, rows[i][0]}, {31'h0, er});
         apb(1'h0, rows[i][72:65], 32'h0, rd, er);
         chk("read data", rows[i][32:1], rd);
         if (rows[i][72:65] == 8'h00)
            chk("power outputs", {26'h0, rows[i][6], 1'h0, rows[i][4:1]},
                {26'h0, master_clock_out_enable, 1'h0, adc_on, pll_on, mic_on, ref_on});
      end
      $display("register table done");
      // reset mid-run held past 150 ns
      reset_n_in <= 1'h0;
      repeat (16) @(posedge ref_clk_in);
      chk("gain in reset", 32'h91, {24'h0, gain});
      chk("power in reset", 32'h0, {27'h0, master_clock_out_enable, adc_on, pll_on, mic_on, ref_on});
      reset_n_in <= 1'h1;
      @(posedge ref_clk_in);
      for (int i = 0; i < 3; i++) begin
         apb(1'h0, 8'(i * 4), 32'h0, rd, er);
         chk("default", i == 2 ? 32'h91 : 32'h0, rd);
      end
      $display("reset test done");
      // clocks, then reference and mic, then ADC
      run_link <= 1'h1;
      apb(1'h1, 8'h00, 32'h03, rd, er);
      apb(1'h1, 8'h00, 32'h0B, rd, er);
      repeat (3080) @(posedge efr);
      chk("valid early", 32'h0, {31'h0, valid});
      repeat (12) @(posedge efr);
      @(posedge ref_clk_in);
      chk("valid after init", 32'h1, {31'h0, valid});
      apb(1'h0, 8'h0C, 32'h0, rd, er);
      chk("status run", 32'h1, rd);
      chk("gain before loop", 32'h91, {24'h0, gain});
      apb(1'h1, 8'h04, 32'h40, rd, er);
      repeat (10) @(posedge efr);
      @(posedge ref_clk_in);
      chk("gain falling", 32'h1, {31'h0, gain inside {[8'h85:8'h8A]}});
      // loop owns the gain while active, so this write must bounce
      apb(1'h1, 8'h08, 32'h10, rd, er);
      chk("gain write refused", 32'h1, {31'h0, gain > 8'h40});
      g = gain;
      peak <= 2'h0;
      repeat (4) @(posedge efr);
      @(posedge ref_clk_in);
      chk("gain rising", 32'h1, {31'h0, gain > g});
      apb(1'h1, 8'h00, 32'h03, rd, er);
      g = gain;
      repeat (20) @(posedge efr);
      @(posedge ref_clk_in);
      chk("gain held while off", {24'h0, g}, {24'h0, gain});
      apb(1'h1, 8'h04, 32'h140, rd, er);
      // pll stays off here: no lock wait, nothing to clear before clocks stop
      run_link <= 1'h0;
      @(posedge ref_clk_in);
      apb(1'h1, 8'h00, 32'h0B, rd, er);
      chk("gain kept on repower", {24'h0, g}, {24'h0, gain});
      $display("init and level test done");
      run_link <= 1'h1;
      apb(1'h1, 8'h00, 32'h41, rd, er);
      repeat (8) @(posedge ref_clk_in);
      edges(128);
      chk("bypass frame toggles", 32'h1, {31'h0, nf inside {[30:34]}});
      chk("bypass bit toggles", 32'h1, {31'h0, nb inside {[62:66]}});
      chk("bypass data toggles", 32'h1, {31'h0, nd inside {[30:34]}});
      $display("bypass test done");
      // outputs freeze once master clock stops
      run_link <= 1'h0;
      run_mclk <= 1'h1;
      apb(1'h1, 8'h00, 32'h81, rd, er);
      edges(256);
      chk("master bit toggles", 32'h1, {31'h0, nb inside {[14:18]}});
      apb(1'h0, 8'h0C, 32'h0, rd, er);
      chk("status mclk running", 32'h4, rd);
      // pll and clock-out enable already clear before the master clock stops
      run_mclk <= 1'h0;
      repeat (150) @(posedge ref_clk_in);
      edges(300);
      chk("outputs frozen", 32'h0, nf + nb + nd);
      apb(1'h0, 8'h00, 32'h0, rd, er);
      chk("ctrl kept", 32'h81, rd);
      apb(1'h0, 8'h0C, 32'h0, rd, er);
      chk("status stopped", 32'h0, rd);
      $display("clock stop test done");
      close_out();
   end
endmodule : testbench
